// >>> design/aht_defines.vh
// constants for the angle hysteresis and turn tracking block
// assumes every user sits on the single system clock sys_clk
`ifndef AHT_DEFINES_VH
`define AHT_DEFINES_VH

// angle widths
`define AHT_ANG_W        14
`define AHT_RD_W         12
`define AHT_ACC_W        21
`define AHT_HYS_W        6
`define AHT_REV_BITS     9
`define AHT_FULL_REV     16384
`define AHT_HALF_CODES   2048

// turn register and its step selection
`define AHT_TURN_ADDR    6'h2C
`define AHT_SH_180       11
`define AHT_SH_45        9

// startup policy field inside configuration word 0x1D
`define AHT_CFG_WORD     6'h1D
`define AHT_POL_MSB      19
`define AHT_POL_LSB      18
`define AHT_POL_ZERO_A   2'h0
`define AHT_POL_ZERO_B   2'h1
`define AHT_POL_ABS      2'h2
`define AHT_POL_BOUND    2'h3

// preload command codes
`define AHT_CMD_PRELOAD  8'h03
`define AHT_INIT_KEY     8'h46

`endif

// >>> design/aht_hysteresis.v
// hysteresis filter on the 14-bit compensated angle
// assumes angle samples come from logic on sys_clk with a valid strobe
`timescale 1ns/1ps
`default_nettype none
`include "aht_defines.vh"

module aht_hysteresis
(
    input  wire                   sys_clk,
    input  wire                   rst_b,
    input  wire                   restart,
    input  wire                   ang_valid,
    input  wire [`AHT_ANG_W-1:0]  ang_in,
    input  wire [`AHT_HYS_W-1:0]  hysteresis_width,
    output reg  [`AHT_ANG_W-1:0]  head,
    output reg                    rotation_direction_flag
);

    reg                   primed;
    reg  [`AHT_ANG_W-1:0] diff;
    reg  [`AHT_ANG_W-1:0] lag;
    wire [`AHT_ANG_W-1:0] width_ext;

    // width counts 14-bit codes: 360/16384 degrees each
    assign width_ext = {{(`AHT_ANG_W-`AHT_HYS_W){1'b0}}, hysteresis_width};

    // distance from head, taken against the reference direction
    always @*
    begin
        diff = ang_in - head;
        if (rotation_direction_flag)
            lag = head - ang_in;
        else
            lag = diff;
    end

    // head follows forward motion, flips only past the far window end
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            head                    <= {`AHT_ANG_W{1'b0}};
            rotation_direction_flag <= 1'b0;
            primed                  <= 1'b0;
        end
        else if (restart)
        begin
            rotation_direction_flag <= 1'b0;
            primed                  <= 1'b0;
        end
        else if (ang_valid)
        begin
            if (!primed)
            begin
                // window placed behind the first angle
                head   <= ang_in;
                primed <= 1'b1;
            end
            else if (lag != {`AHT_ANG_W{1'b0}} && !lag[`AHT_ANG_W-1])
                head <= ang_in;
            else if ((~lag + 1'b1) > width_ext)
            begin
                head                    <= ang_in;
                rotation_direction_flag <= ~rotation_direction_flag;
            end
            // otherwise inside the window: output frozen
        end
    end

endmodule // aht_hysteresis
`default_nettype wire

// >>> design/aht_turn_tracker.v
// angle hysteresis filter and multi-revolution turn tracker
// assumes all inputs come from logic on sys_clk; serial protocol and
// nonvolatile memory live outside and present fields as plain ports
//
// Functional notes
// - hysteresis window width is field value times 360/16384 degrees.
// - filtered angle readable at 12-bit resolution beside raw angle.
// - forward motion passes measured angle straight to filtered output.
// - on reversal filtered output holds until angle leaves window.
// - exit on far side moves head there and reverses direction.
// - direction flag 0 means increasing, 1 means decreasing.
// - reset or self-test: direction increasing, window behind first angle.
// - turn source select 0 takes angle from zero-crossing path.
// - accumulate angle changes; 24-bit word is angle plus extended revolutions.
// - accumulator holds 21 bits of position relative to reference.
// - turn count is upper 10 bits (180 mode) or 12 (45 mode).
// - turn range -512..511 or -2048..2047 depending on step.
// - startup policy comes from bits 19:18 of configuration word 0x1D.
// - policy 00 or 01 clears accumulator at startup.
// - policy 10 loads accumulator with angle seen at startup.
// - policy 11 loads offset past lower step boundary, count zero.
// - 2048 accumulator codes equal 180 degrees.
// - preload stages 21 bits, then command 0x03 and key 0x46.
// - policy 10 or 11 preload snaps to value matching sensed angle.
`timescale 1ns/1ps
`default_nettype none
`include "aht_defines.vh"

module aht_turn_tracker
(
    input  wire                   sys_clk,
    input  wire                   rst_b,
    input  wire                   logic_builtin_selftest,
    input  wire                   ang_valid,
    input  wire [`AHT_ANG_W-1:0]  ang_in,
    input  wire [`AHT_RD_W-1:0]   zero_crossing_path,
    input  wire                   turn_source_select,
    input  wire                   fine_turn_step_select,
    input  wire [`AHT_HYS_W-1:0]  hysteresis_width,
    input  wire [23:0]            cfg_word,
    input  wire [15:0]            staging_data_high,
    input  wire [15:0]            staging_data_low,
    input  wire [7:0]             command_code_field,
    input  wire                   initiate_wr,
    input  wire [7:0]             initiate_code,
    output reg  [`AHT_RD_W-1:0]   raw_angle_readout,
    output reg  [`AHT_RD_W-1:0]   filtered_angle_readout,
    output wire                   rotation_direction_flag,
    output reg  [15:0]            turn_count_readout,
    output reg  [23:0]            accumulated_position_word,
    output reg                    tracker_ready,
    output reg                    preload_done
);

    // tracker states
    localparam ST_INIT = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg                   state;
    reg                   next_state;
    reg  [`AHT_ACC_W-1:0] acc;
    reg  [`AHT_ACC_W-1:0] next_acc;
    reg  [`AHT_RD_W-1:0]  prev_ang;
    reg  [`AHT_RD_W-1:0]  next_prev_ang;
    reg                   next_done;

    wire [`AHT_ANG_W-1:0] hys_head;
    wire [`AHT_RD_W-1:0]  src_ang;
    wire [1:0]            policy;
    wire [`AHT_ACC_W-1:0] staged;
    wire                  preload_req;
    wire [`AHT_RD_W-1:0]  step;
    wire [`AHT_ACC_W-1:0] moved;

    // sign-extend a 12-bit signed code to the accumulator width
    function [`AHT_ACC_W-1:0] sext12;
        input [`AHT_RD_W-1:0] v;
        begin
            sext12 = {{(`AHT_ACC_W-`AHT_RD_W){v[`AHT_RD_W-1]}}, v};
        end
    endfunction

    // turn count from the accumulator, extended to 16 bits
    function [15:0] turn_of;
        input [`AHT_ACC_W-1:0] a;
        input                  fine;
        begin
            if (fine)
                turn_of = {{4{a[`AHT_ACC_W-1]}},
                           a[`AHT_ACC_W-1:`AHT_SH_45]};
            else
                turn_of = {{6{a[`AHT_ACC_W-1]}},
                           a[`AHT_ACC_W-1:`AHT_SH_180]};
        end
    endfunction

    // residue past the lower step boundary for the chosen step
    function [`AHT_ACC_W-1:0] bound_off;
        input [`AHT_RD_W-1:0] ang;
        input                 fine;
        begin
            if (fine)
                bound_off = {{(`AHT_ACC_W-`AHT_SH_45){1'b0}},
                             ang[`AHT_SH_45-1:0]};
            else
                bound_off = {{(`AHT_ACC_W-`AHT_SH_180){1'b0}},
                             ang[`AHT_SH_180-1:0]};
        end
    endfunction

    // hysteresis filter on the full 14-bit angle
    aht_hysteresis u_hys
    (
        .sys_clk                 (sys_clk),
        .rst_b                   (rst_b),
        .restart                 (logic_builtin_selftest),
        .ang_valid               (ang_valid),
        .ang_in                  (ang_in),
        .hysteresis_width        (hysteresis_width),
        .head                    (hys_head),
        .rotation_direction_flag (rotation_direction_flag)
    );

    // source of the turn path; zero-crossing path when select is low
    assign src_ang = turn_source_select ? ang_in[`AHT_ANG_W-1:2]
                                        : zero_crossing_path;

    // startup policy field of configuration word 0x1D
    assign policy = cfg_word[`AHT_POL_MSB:`AHT_POL_LSB];

    // staged value: five upper bits in high word, sixteen in low word
    assign staged = {staging_data_high[4:0], staging_data_low};

    // both codes must be present in the same initiate write
    assign preload_req = initiate_wr
                       && (initiate_code == `AHT_INIT_KEY)
                       && (command_code_field == `AHT_CMD_PRELOAD);

    // 12-bit wrap gives the shortest signed change across 0 degrees
    assign step  = src_ang - prev_ang;
    assign moved = acc + sext12(step);

    // accumulator, startup policy and preload handling
    always @*
    begin
        next_state    = state;
        next_acc      = acc;
        next_prev_ang = prev_ang;
        next_done     = 1'b0;
        case (state)
            ST_INIT:
            begin
                if (ang_valid)
                begin
                    next_prev_ang = src_ang;
                    next_state    = ST_RUN;
                    case (policy)
                        `AHT_POL_ABS:
                            // 4096 codes per turn, 2048 per half
                            next_acc = sext12(src_ang) &
                                       {{(`AHT_ACC_W-`AHT_RD_W){1'b0}},
                                        {`AHT_RD_W{1'b1}}};
                        `AHT_POL_BOUND:
                            next_acc = bound_off(src_ang,
                                           fine_turn_step_select);
                        default:
                            next_acc = {`AHT_ACC_W{1'b0}};
                    endcase
                end
            end
            ST_RUN:
            begin
                if (ang_valid)
                begin
                    next_acc      = moved;
                    next_prev_ang = src_ang;
                end
                if (preload_req)
                begin
                    next_done = 1'b1;
                    if (policy[1])
                        // keep the phase the sensed angle gives, take
                        // the nearest staged position: errors under
                        // half a turn vanish
                        next_acc = staged + sext12(next_acc[`AHT_RD_W-1:0]
                                   - staged[`AHT_RD_W-1:0]);
                    else
                        next_acc = staged;
                end
            end
            default:
            begin
                next_state = ST_INIT;
            end
        endcase
        // self-test restarts the startup sequence
        if (logic_builtin_selftest)
        begin
            next_state = ST_INIT;
            next_done  = 1'b0;
        end
    end

    // state registers
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state        <= ST_INIT;
            acc          <= {`AHT_ACC_W{1'b0}};
            prev_ang     <= {`AHT_RD_W{1'b0}};
            preload_done <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            acc          <= next_acc;
            prev_ang     <= next_prev_ang;
            preload_done <= next_done;
        end
    end

    // readout registers, one cycle behind the state they show
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            raw_angle_readout         <= {`AHT_RD_W{1'b0}};
            filtered_angle_readout    <= {`AHT_RD_W{1'b0}};
            turn_count_readout        <= 16'h0000;
            accumulated_position_word <= 24'h000000;
            tracker_ready             <= 1'b0;
        end
        else
        begin
            raw_angle_readout      <= ang_in[`AHT_ANG_W-1:2];
            // head is the held output; low two bits dropped
            filtered_angle_readout <= hys_head[`AHT_ANG_W-1:2];
            // range follows the field width: 10 or 12 signed bits
            turn_count_readout <= turn_of(acc,
                                          fine_turn_step_select);
            // nine revolution bits stretched to twelve over the angle
            accumulated_position_word <=
                {{3{acc[`AHT_ACC_W-1]}}, acc};
            tracker_ready <= (state == ST_RUN);
        end
    end

endmodule // aht_turn_tracker
`default_nettype wire

// >>> testbench/aht_host_model.sv
// host controller model that stages and launches a position preload
// assumes it shares sys_clk with the tracker and drives after edges
`timescale 1ns/1ps
`default_nettype none
module aht_host_model
(
    input  wire logic        sys_clk,
    output var  logic [15:0] staging_data_high,
    output var  logic [15:0] staging_data_low,
    output var  logic [7:0]  command_code_field,
    output var  logic        initiate_wr,
    output var  logic [7:0]  initiate_code
);
    // idle bus; key kept off so a stray strobe cannot fire
    initial
    begin
        staging_data_high = 16'h0000;
        staging_data_low = 16'h0000;
        command_code_field = 8'h00;
        initiate_wr = 1'b0;
        initiate_code = 8'h00;
    end
    // stage 21 bits, command, then key strobe held over one edge
    task automatic preload(input logic [20:0] v);
    begin
        @(posedge sys_clk);
        #2;
        staging_data_high = {11'h000, v[20:16]};
        staging_data_low = v[15:0];
        command_code_field = 8'h03;
        initiate_code = 8'h46;
        initiate_wr = 1'b1;
        @(posedge sys_clk);
        #2;
        initiate_wr = 1'b0;
        initiate_code = 8'hB9; // released: inverse of the key
        command_code_field = 8'hFC;
        repeat (2) @(posedge sys_clk);
        #2;
    end
    endtask
endmodule // aht_host_model
`default_nettype wire

// >>> testbench/aht_turn_tracker_properties.sv
// port-level assertions for the angle turn tracker
// bound into every aht_turn_tracker; single clock domain
`timescale 1ns/1ps
`default_nettype none
module aht_turn_tracker_properties
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        logic_builtin_selftest,
    input wire logic        ang_valid,
    input wire logic [13:0] ang_in,
    input wire logic        initiate_wr,
    input wire logic [7:0]  initiate_code,
    input wire logic [7:0]  command_code_field,
    input wire logic        fine_turn_step_select,
    input wire logic [11:0] raw_angle_readout,
    input wire logic [11:0] filtered_angle_readout,
    input wire logic        rotation_direction_flag,
    input wire logic [15:0] turn_count_readout,
    input wire logic [23:0] accumulated_position_word,
    input wire logic        tracker_ready,
    input wire logic        preload_done
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // short aliases keep the properties on one line
    wire [23:0] apw = accumulated_position_word;
    wire        fine = fine_turn_step_select;

    property p_pos_sext;
        apw[23:21] == {3{apw[20]}};
    endproperty
    a_pos_sext: assert property (p_pos_sext)
        else $error("position word not sign extended");
    // guard on a steady step select: the readout lags a change by one edge
    property p_turn_180;
        !fine && $stable(fine) |->
            turn_count_readout == {{6{apw[20]}}, apw[20:11]};
    endproperty
    a_turn_180: assert property (p_turn_180)
        else $error("half turn count wrong");
    property p_turn_45;
        fine && $stable(fine) |->
            turn_count_readout == {{4{apw[20]}}, apw[20:9]};
    endproperty
    a_turn_45: assert property (p_turn_45)
        else $error("eighth turn count wrong");
    property p_done_cause;
        preload_done |-> $past(initiate_wr && initiate_code == 8'h46
            && command_code_field == 8'h03);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("preload without command and key");
    // a keyed command while tracking must be answered one edge later
    property p_done_follows;
        initiate_wr && initiate_code == 8'h46 && command_code_field == 8'h03
            && tracker_ready && !logic_builtin_selftest
            && !$past(logic_builtin_selftest) |=> preload_done;
    endproperty
    a_done_follows: assert property (p_done_follows)
        else $error("keyed preload not applied");
    property p_raw;
        ang_valid |=> raw_angle_readout == $past(ang_in[13:2]);
    endproperty
    a_raw: assert property (p_raw)
        else $error("raw angle readout wrong");
    property p_flag_cause;
        $changed(rotation_direction_flag) |->
            $past(ang_valid) || $past(logic_builtin_selftest);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("direction moved without a sample");
    property p_selftest;
        logic_builtin_selftest |=> !rotation_direction_flag;
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("self test left direction decreasing");
    property p_filt_hold;
        $changed(filtered_angle_readout) |-> $past(ang_valid, 2);
    endproperty
    a_filt_hold: assert property (p_filt_hold)
        else $error("filtered angle moved without a sample");
    property p_acc_cause;
        $changed(apw) |-> $past(ang_valid, 2) || $past(preload_done);
    endproperty
    a_acc_cause: assert property (p_acc_cause)
        else $error("position moved without cause");
    // main scenarios reached
    c_preload: cover property (preload_done);
    c_flip: cover property ($rose(rotation_direction_flag));
    c_fine: cover property (fine && ang_valid);
endmodule // aht_turn_tracker_properties
bind aht_turn_tracker aht_turn_tracker_properties
    i_aht_turn_tracker_properties (.*);
`default_nettype wire

// >>> testbench/tb_aht_turn_tracker.sv
// self-checking bench for the angle hysteresis and turn tracker
// assumes design and host model compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_aht_turn_tracker;
    logic        sys_clk = 1'b0, rst_b = 1'b0, ang_valid = 1'b0;
    logic        logic_builtin_selftest = 1'b0;
    logic        turn_source_select = 1'b1, fine_turn_step_select = 1'b0;
    logic [13:0] ang_in = 14'h0000;
    logic [11:0] zero_crossing_path = 12'h000;
    logic [5:0]  hysteresis_width = 6'h08;
    logic [23:0] cfg_word = 24'h000000;
    logic [15:0] staging_data_high, staging_data_low, turn_count_readout;
    logic [7:0]  command_code_field, initiate_code;
    logic        initiate_wr, rotation_direction_flag;
    logic        tracker_ready, preload_done;
    logic [11:0] raw_angle_readout, filtered_angle_readout;
    logic [23:0] accumulated_position_word;
    int          failures = 0, check_count = 0;

    aht_turn_tracker i_aht_turn_tracker (.*);
    aht_host_model i_aht_host_model (.*);

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    task automatic tick;
    begin
        @(posedge sys_clk);
        #2;
    end
    endtask
    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
    begin
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task automatic restart(input logic [1:0] pol);
    begin
        rst_b = 1'b0;
        cfg_word = {4'h0, pol, 18'h00000};
        repeat (8) tick;
        rst_b = 1'b1;
        tick;
    end
    endtask
    // one sample, then wait until readouts carry it
    task automatic samp(input logic [13:0] a);
    begin
        ang_in = a;
        ang_valid = 1'b1;
        tick;
        ang_valid = 1'b0;
        repeat (2) tick;
    end
    endtask
    task automatic tally_and_finish;
    begin
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // hang guard, far beyond the fewer than a hundred cycles of the run
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        tally_and_finish;
    end

    // main sequence
    initial
    begin
        restart(2'b00);
        samp(14'h0400);
        check("ready", 24'h1, {23'h0, tracker_ready});
        check("pos", 24'h0, accumulated_position_word);
        check("raw", 24'h100, {12'h0, raw_angle_readout});
        samp(14'h0C00);
        check("pos", 24'h000200, accumulated_position_word);
        check("filt", 24'h300, {12'h0, filtered_angle_readout});
        samp(14'h0BFC);
        check("filt", 24'h300, {12'h0, filtered_angle_readout});
        check("dir", 24'h0, {23'h0, rotation_direction_flag});
        samp(14'h0BF0);
        check("dir", 24'h1, {23'h0, rotation_direction_flag});
        samp(14'h0BE0);
        check("filt", 24'h2F8, {12'h0, filtered_angle_readout});
        samp(14'h0000);
        check("pos", 24'hFFFF00, accumulated_position_word);
        check("turn", 24'h00FFFF, {8'h0, turn_count_readout});
        i_aht_host_model.preload(21'h01D00F);
        check("pos", 24'h01D00F, accumulated_position_word);
        check("turn", 24'h00003A, {8'h0, turn_count_readout});
        logic_builtin_selftest = 1'b1;
        tick;
        logic_builtin_selftest = 1'b0;
        tick;
        check("dir", 24'h0, {23'h0, rotation_direction_flag});
        // alternate source moves the position while the angle stands still
        turn_source_select = 1'b0;
        zero_crossing_path = 12'h100;
        restart(2'b01);
        samp(14'h2000);
        zero_crossing_path = 12'h300;
        samp(14'h2000);
        check("pos", 24'h000200, accumulated_position_word);
        turn_source_select = 1'b1;
        restart(2'b10);
        samp(14'h3000);
        check("pos", 24'h000C00, accumulated_position_word);
        check("turn", 24'h000001, {8'h0, turn_count_readout});
        fine_turn_step_select = 1'b1;
        repeat (2) tick;
        check("turn", 24'h000006, {8'h0, turn_count_readout});
        i_aht_host_model.preload(21'h01D00F);
        check("pos", 24'h01CC00, accumulated_position_word);
        fine_turn_step_select = 1'b0;
        restart(2'b11);
        samp(14'h3000);
        check("pos", 24'h000400, accumulated_position_word);
        check("turn", 24'h000000, {8'h0, turn_count_readout});
        tally_and_finish;
    end
endmodule // tb_aht_turn_tracker
`default_nettype wire
